// ===== rtl/pwel_regs.svh
/*
 * Register offsets, field positions and reset values of the wake event block.
 * Assumes byte addressing on a 32-bit AXI4-Lite bus; byte address is four times the index.
 */
`ifndef PWEL_REGS_SVH
`define PWEL_REGS_SVH

`define PWEL_IDX_OUT_GATE      8'hC5
`define PWEL_IDX_EVENT_FLAG    8'hC6
`define PWEL_IDX_SRC_STATUS    8'hC7
`define PWEL_IDX_SRC_ENABLE    8'hC8
`define PWEL_ADDR_OUT_GATE     12'h0314
`define PWEL_ADDR_EVENT_FLAG   12'h0318
`define PWEL_ADDR_SRC_STATUS   12'h031C
`define PWEL_ADDR_SRC_ENABLE   12'h0320
`define PWEL_BIT_GATE          0
`define PWEL_BIT_FLAG          0
`define PWEL_BIT_RING_SECOND   1
`define PWEL_BIT_RING_FIRST    2
`define PWEL_BIT_KEYBOARD      3
`define PWEL_BIT_MOUSE         4
`define PWEL_SRC_MASK          8'h1E
`define PWEL_RESET_VALUE       8'h00
`define PWEL_RESP_OKAY         2'h0
`define PWEL_RESP_SLVERR       2'h2

`endif

// ===== rtl/pwel_pkg.sv
/*
 * Types shared by the wake event block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwel_pkg;
    typedef enum logic [1:0] {
        PWEL_WR_IDLE,
        PWEL_WR_RESP
    } pwel_wr_state_e;
    typedef logic [7:0] pwel_byte_t;
endpackage

// ===== rtl/pwel_w1c_bit.sv
/*
 * One sticky status bit: set by a hardware event, cleared by writing 1.
 * Assumes synchronous active-low reset on the standby supply.
 */
module pwel_w1c_bit (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic set_event,
    input  wire logic clear_write,
    output logic      flag_reg
);
    logic flag_next;

    // set wins over a clear in the same cycle
    assign flag_next = set_event | (flag_reg & ~clear_write);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    a_set_wins : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R1 R5
        set_event |=> flag_reg) else $error("sticky bit lost an event");
    a_clear_takes : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R3 R8
        (clear_write && !set_event) |=> !flag_reg) else $error("sticky bit not cleared");
    a_hold_zero : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R4 R9
        (!clear_write && flag_reg) |=> flag_reg) else $error("sticky bit dropped on its own");
endmodule // pwel_w1c_bit

// ===== rtl/pwel_wake_event.sv
/*
 * Wake event logic: four wake sources, sticky status, per-source enables,
 * a global output gate and an active-low wake request, on an AXI4-Lite slave.
 * Assumes wake inputs synchronous to clk_sys, high for an event; reset_n is
 * the standby-supply power-on reset only, so main-supply resets never reach it.
 */
`include "pwel_regs.svh"

// Behaviour
// R1: global flag sets whenever a request would be raised, gate or no gate.
// R2: global flag is zero after standby power-on, kept through other resets.
// R3: writing 1 clears the global flag and releases the request.
// R4: writing 0 to the global flag changes nothing.
// R5: source status shows each source's activity regardless of any enable.
// R6: status bits: 1 ring second, 2 ring first, 3 keyboard, 4 mouse.
// R7: source status is zero after standby power-on, kept through other resets.
// R8: writing 1 to a low status bit clears it.
// R9: writing 0 to a status bit leaves it unchanged.
// R10: enabled source event with gate on asserts the request.
// R11: disabled source event is recorded but never asserts the request.
// R12: enable register is zero after standby power-on, kept through other resets.
// R13: control bit 0 is the output gate, default 0 blocks the request.
// R14: request low while global flag set and gate on, released otherwise.
// R15: enabled source event sets global flag; reserved bits read zero.
module pwel_wake_event (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        ring_indicate_first,
    input  wire logic        ring_indicate_second,
    input  wire logic        keyboard_wake,
    input  wire logic        mouse_wake,
    output logic             wake_request_n,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // write channel: capture address and data in either order

    logic                   aw_held_reg;
    logic                   w_held_reg;
    logic [11:0]            aw_addr_reg;
    logic [7:0]             w_data_reg;
    logic                   w_lane0_reg;
    pwel_pkg::pwel_wr_state_e wr_state_reg;
    logic                   wr_fire;
    logic                   wr_mapped;
    logic                   wr_gate_hit;
    logic                   wr_flag_hit;
    logic                   wr_status_hit;
    logic                   wr_enable_hit;

    assign s_axi_awready = !aw_held_reg && (wr_state_reg == pwel_pkg::PWEL_WR_IDLE);
    assign s_axi_wready  = !w_held_reg && (wr_state_reg == pwel_pkg::PWEL_WR_IDLE);
    assign wr_fire       = aw_held_reg && w_held_reg;
    assign wr_gate_hit   = wr_fire && w_lane0_reg && (aw_addr_reg == `PWEL_ADDR_OUT_GATE);
    assign wr_flag_hit   = wr_fire && w_lane0_reg && (aw_addr_reg == `PWEL_ADDR_EVENT_FLAG);
    assign wr_status_hit = wr_fire && w_lane0_reg && (aw_addr_reg == `PWEL_ADDR_SRC_STATUS);
    assign wr_enable_hit = wr_fire && w_lane0_reg && (aw_addr_reg == `PWEL_ADDR_SRC_ENABLE);
    assign wr_mapped     = (aw_addr_reg == `PWEL_ADDR_OUT_GATE)
                        || (aw_addr_reg == `PWEL_ADDR_EVENT_FLAG)
                        || (aw_addr_reg == `PWEL_ADDR_SRC_STATUS)
                        || (aw_addr_reg == `PWEL_ADDR_SRC_ENABLE);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            aw_addr_reg  <= 12'h0000;
            w_data_reg   <= `PWEL_RESET_VALUE;
            w_lane0_reg  <= 1'b0;
            wr_state_reg <= pwel_pkg::PWEL_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PWEL_RESP_OKAY;
        end else begin
            case (wr_state_reg)
                pwel_pkg::PWEL_WR_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_held_reg <= 1'b1;
                        aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_held_reg  <= 1'b1;
                        w_data_reg  <= s_axi_wdata[7:0];
                        w_lane0_reg <= s_axi_wstrb[0];
                    end
                    if (wr_fire) begin
                        aw_held_reg  <= 1'b0;
                        w_held_reg   <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_mapped ? `PWEL_RESP_OKAY : `PWEL_RESP_SLVERR;
                        wr_state_reg <= pwel_pkg::PWEL_WR_RESP;
                    end
                end
                pwel_pkg::PWEL_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_reg <= pwel_pkg::PWEL_WR_IDLE;
                    end
                end
                default: begin
                    wr_state_reg <= pwel_pkg::PWEL_WR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake registers; reset_n is the standby-supply reset only

    logic       wake_output_gate_reg;
    logic [7:0] wake_source_enable_reg;
    logic [7:0] wake_source_status;
    logic [7:0] wake_source_event;
    logic [7:0] status_clear;
    logic       wake_event_flag;
    logic       flag_set;
    logic       flag_clear;

    // see R6
    assign wake_source_event = {3'b000, mouse_wake, keyboard_wake,
                                ring_indicate_first, ring_indicate_second, 1'b0};
    // see R8, R9
    assign status_clear = wr_status_hit ? (w_data_reg & `PWEL_SRC_MASK) : 8'h00;
    // see R1, R11, R15
    assign flag_set     = |(wake_source_event & wake_source_enable_reg);
    // see R3, R4
    assign flag_clear   = wr_flag_hit && w_data_reg[`PWEL_BIT_FLAG];

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wake_output_gate_reg   <= 1'b0;             // see R13
            wake_source_enable_reg <= `PWEL_RESET_VALUE; // see R12
        end else begin
            if (wr_gate_hit) begin
                wake_output_gate_reg <= w_data_reg[`PWEL_BIT_GATE];
            end
            if (wr_enable_hit) begin
                wake_source_enable_reg <= w_data_reg & `PWEL_SRC_MASK;
            end
        end
    end

    // sticky source bits, see R5, R7
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_status
            if (((`PWEL_SRC_MASK >> gi) & 1) != 0) begin : g_live
                pwel_w1c_bit u_bit (
                    .clk_sys     (clk_sys),
                    .reset_n     (reset_n),
                    .set_event   (wake_source_event[gi]),
                    .clear_write (status_clear[gi]),
                    .flag_reg    (wake_source_status[gi])
                );
            end else begin : g_rsvd
                assign wake_source_status[gi] = 1'b0;   // see R15
            end
        end
    endgenerate

    // global flag, see R2
    pwel_w1c_bit u_flag (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .set_event   (flag_set),
        .clear_write (flag_clear),
        .flag_reg    (wake_event_flag)
    );

    // see R10, R14
    assign wake_request_n = ~(wake_event_flag & wake_output_gate_reg);

    ////////////////////////////////////////////////////////////////////////////
    // read channel

    logic [11:0] rd_addr;
    logic [7:0]  rd_byte;
    logic        rd_mapped;

    assign rd_addr   = {s_axi_araddr[11:2], 2'b00};
    assign rd_mapped = (rd_addr == `PWEL_ADDR_OUT_GATE)
                    || (rd_addr == `PWEL_ADDR_EVENT_FLAG)
                    || (rd_addr == `PWEL_ADDR_SRC_STATUS)
                    || (rd_addr == `PWEL_ADDR_SRC_ENABLE);
    assign rd_byte   = (rd_addr == `PWEL_ADDR_OUT_GATE)   ? {7'h00, wake_output_gate_reg} :
                       (rd_addr == `PWEL_ADDR_EVENT_FLAG) ? {7'h00, wake_event_flag} :
                       (rd_addr == `PWEL_ADDR_SRC_STATUS) ? wake_source_status :
                       (rd_addr == `PWEL_ADDR_SRC_ENABLE) ? wake_source_enable_reg : 8'h00;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PWEL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_mapped ? `PWEL_RESP_OKAY : `PWEL_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_flag_nogate : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R1
        (flag_set && !wake_output_gate_reg) |=> wake_event_flag)
        else $error("flag not set while gate off");
    a_req_enabled : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R10
        (flag_set && wake_output_gate_reg && !wr_gate_hit) |=> !wake_request_n)
        else $error("enabled event did not assert request");
    a_req_release : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R3
        (flag_clear && !flag_set) |=> wake_request_n)
        else $error("request not released on clear");
    a_req_gated : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R13
        !wake_output_gate_reg |-> wake_request_n)
        else $error("request asserted with gate off");
    a_req_matches : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R14
        !wake_request_n |-> (wake_event_flag && wake_output_gate_reg))
        else $error("request without flag and gate");
    a_status_free : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R5
        keyboard_wake |=> wake_source_status[`PWEL_BIT_KEYBOARD])
        else $error("keyboard status not recorded");
    a_disabled_quiet : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R11
        (!wake_event_flag && !flag_set) |=> !wake_event_flag)
        else $error("flag set by disabled source");
    a_zero_write : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R4
        (wr_flag_hit && !w_data_reg[`PWEL_BIT_FLAG] && wake_event_flag) |=> wake_event_flag)
        else $error("zero write cleared flag");
    a_rsvd_zero : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R15
        (wake_source_status & ~`PWEL_SRC_MASK) == 8'h00
        && (wake_source_enable_reg & ~`PWEL_SRC_MASK) == 8'h00)
        else $error("reserved bits nonzero");

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake, register write and status record checks

    sequence s_wr_both_held;
        aw_held_reg && w_held_reg;
    endsequence

    sequence s_wr_answered;
        s_axi_bvalid && (wr_state_reg == pwel_pkg::PWEL_WR_RESP);
    endsequence

    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_rd_answered;
        s_axi_rvalid && (s_axi_rdata[31:8] == 24'h00_0000);
    endsequence

    a_wr_answer : assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_wr_both_held |=> s_wr_answered)
        else $error("write response missing");
    a_busy_refuse : assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_state_reg == pwel_pkg::PWEL_WR_RESP) |-> (!s_axi_awready && !s_axi_wready))
        else $error("write taken while response pending");
    a_bvalid_holds : assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped early");
    a_rd_answer : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R15
        s_rd_taken |=> s_rd_answered)
        else $error("read response missing or upper bits set");
    a_rvalid_holds : assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read data dropped early");
    a_gate_write : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R13
        wr_gate_hit |=> (wake_output_gate_reg == w_data_reg[`PWEL_BIT_GATE]))
        else $error("gate write not applied");
    a_enable_write : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R10
        wr_enable_hit |=> (wake_source_enable_reg == (w_data_reg & `PWEL_SRC_MASK)))
        else $error("enable write not applied");
    a_mouse_clear : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R8
        (status_clear[`PWEL_BIT_MOUSE] && !mouse_wake) |=> !wake_source_status[`PWEL_BIT_MOUSE])
        else $error("mouse status not cleared");
    a_mouse_keep : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R9
        (wr_status_hit && !w_data_reg[`PWEL_BIT_MOUSE]
            && wake_source_status[`PWEL_BIT_MOUSE]) |=> wake_source_status[`PWEL_BIT_MOUSE])
        else $error("mouse status lost on zero write");
    a_ring_record : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R6
        ring_indicate_second |=> wake_source_status[`PWEL_BIT_RING_SECOND])
        else $error("ring second status not recorded");
    a_flag_readback : assert property (@(posedge clk_sys) disable iff (!reset_n) // see R1
        (s_rd_taken ##0 (rd_addr == `PWEL_ADDR_EVENT_FLAG))
        |=> (s_axi_rdata[7:0] == {7'h00, $past(wake_event_flag)}))
        else $error("flag read back wrong");
endmodule // pwel_wake_event

// ===== dv/pwel_chipset_model.sv
/* Chipset side of the wake request: remembers that a request was seen.
   Assumes wake_request_n is active low and synchronous to clk_sys. */
module pwel_chipset_model (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic wake_request_n,
    output logic      wake_seen_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wake_seen_reg <= 1'b0;
        end else if (!wake_request_n) begin
            wake_seen_reg <= 1'b1;
        end
    end
endmodule // pwel_chipset_model

// ===== dv/tb_top.sv
/* Bench top: AXI4-Lite master, wake input driver and behavioural model.
   Assumes pwel_regs.svh on the include path and one 100 MHz clock. */
`include "pwel_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, reset_n = 1'b0;
    logic        ring_indicate_first = 1'b0, ring_indicate_second = 1'b0;
    logic        keyboard_wake = 1'b0, mouse_wake = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        wake_request_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, wake_seen;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] rd;
    int          num_errors = 0, tests_run = 0, seed = 32'h2774;
    int          mdl [4];  // gate, flag, status, enable

    always #5 clk_sys = ~clk_sys;

    pwel_wake_event pwel_wake_event_inst (
        .clk_sys, .reset_n, .ring_indicate_first, .ring_indicate_second,
        .keyboard_wake, .mouse_wake, .wake_request_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    pwel_chipset_model pwel_chipset_model_inst (
        .clk_sys, .reset_n, .wake_request_n, .wake_seen_reg(wake_seen));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] addr_of(input int i);
        case (i)
            0: addr_of = `PWEL_ADDR_OUT_GATE;
            1: addr_of = `PWEL_ADDR_EVENT_FLAG;
            2: addr_of = `PWEL_ADDR_SRC_STATUS;
            default: addr_of = `PWEL_ADDR_SRC_ENABLE;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic op_wr(input int i, input logic [7:0] d);
        axi_wr(addr_of(i), {24'h00_0000, d}, rs);
        chk({30'd0, rs}, {30'd0, `PWEL_RESP_OKAY});
        case (i)
            0: mdl[0] = int'(d[0]);
            1: if (d[0]) mdl[1] = 0;
            2: mdl[2] = mdl[2] & ~(int'(d) & 32'h0000_001F);
            default: mdl[3] = int'(d) & 32'h0000_001E;
        endcase
    endtask

    // one-cycle pulse; w is mouse, keyboard, ring first, ring second
    task automatic op_ev(input logic [3:0] w);
        @(posedge clk_sys);
        {mouse_wake, keyboard_wake, ring_indicate_first, ring_indicate_second} <= w;
        @(posedge clk_sys);
        {mouse_wake, keyboard_wake, ring_indicate_first, ring_indicate_second} <= 4'h0;
        mdl[2] = mdl[2] | (int'(w) << 1);
        if (((mdl[3] >> 1) & int'(w)) != 0) mdl[1] = 1;
    endtask

    task automatic check_all;
        for (int i = 0; i < 4; i++) begin
            axi_rd(addr_of(i), rd, rs);
            chk(rd, 32'(mdl[i]));
            chk({30'd0, rs}, {30'd0, `PWEL_RESP_OKAY});
        end
        chk({31'd0, wake_request_n}, {31'd0, !(mdl[0] != 0 && mdl[1] != 0)});
    endtask

    task automatic final_report;
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mdl = '{0, 0, 0, 0};
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        check_all;
        chk({31'd0, wake_seen}, 32'h0000_0000);
        // lane 0 strobe low: write ignored, still answered
        s_axi_wstrb <= 4'h0;
        axi_wr(`PWEL_ADDR_OUT_GATE, 32'h0000_0001, rs);
        chk({30'd0, rs}, {30'd0, `PWEL_RESP_OKAY});
        s_axi_wstrb <= 4'hF;
        check_all;
        axi_rd(12'h324, rd, rs);
        chk({30'd0, rs}, {30'd0, `PWEL_RESP_SLVERR});
        chk(rd, 32'h0000_0000);
        axi_wr(12'h000, 32'hFFFF_FFFF, rs);
        chk({30'd0, rs}, {30'd0, `PWEL_RESP_SLVERR});
        for (int s = 0; s < 4; s++) begin
            op_ev(4'h1 << s);
            check_all;
        end
        op_wr(2, 8'h00);
        check_all;
        op_wr(2, 8'h0A);
        check_all;
        op_wr(3, 8'hFF);
        op_ev(4'h4);
        check_all;
        op_wr(0, 8'h01);
        check_all;
        chk({31'd0, wake_seen}, 32'h0000_0001);
        op_wr(1, 8'h00);
        check_all;
        op_wr(1, 8'h01);
        check_all;
        op_wr(3, 8'h02);
        op_ev(4'hE);
        check_all;
        op_ev(4'h1);
        check_all;
        for (int k = 0; k < 30; k++) begin
            if ($random(seed) & 1) op_wr($random(seed) & 3, 8'($random(seed)));
            else op_ev(4'($random(seed)));
            check_all;
        end
        final_report;
    end

    initial begin
        #100000;
        num_errors++;
        final_report;
    end
endmodule // tb_top
